// [inc/lookup_cfg_pkg.sv]
// constants for the global lookup configuration register bank
package lookup_cfg_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_MAX_PAYLOAD = 12'h308;
    localparam logic [11:0] IDX_TAG_TYPE = 12'h30A;
    localparam logic [11:0] IDX_LOOKUP_CTL = 12'h310;
    localparam logic [11:0] IDX_STATUS = 12'h314;
    localparam logic [11:0] ADDR_MAX_PAYLOAD = 12'(IDX_MAX_PAYLOAD * 4);
    localparam logic [11:0] ADDR_TAG_TYPE = 12'(IDX_TAG_TYPE * 4);
    localparam logic [11:0] ADDR_LOOKUP_CTL = 12'(IDX_LOOKUP_CTL * 4);
    localparam logic [11:0] ADDR_STATUS = 12'(IDX_STATUS * 4);

    // reset values
    localparam logic [15:0] MAX_PAYLOAD_RST = 16'h07D0;
    localparam logic [15:0] TAG_TYPE_RST = 16'h9100;
    localparam logic [7:0] LOOKUP_CTL_RST = 8'h61;

    // field positions
    localparam int LIMIT_MSB = 13;
    localparam int CTL_VLAN_EN = 7;
    localparam int CTL_DROP_INVALID = 6;
    localparam int CTL_AGE_MSB = 5;
    localparam int CTL_AGE_LSB = 3;
    localparam int CTL_RSVD_MCAST = 2;
    localparam int CTL_INDEX_MSB = 1;
    localparam int STATUS_DROP_LSB = 8;

    // index select encodings
    localparam logic [1:0] INDEX_DIRECT0 = 2'h0;
    localparam logic [1:0] INDEX_CRC = 2'h1;
    localparam logic [1:0] INDEX_XOR = 2'h2;
    localparam logic [1:0] INDEX_DIRECT3 = 2'h3;

    localparam int INDEX_W = 10;
    localparam logic [9:0] CRC_POLY = 10'h233;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [verilog/table_index_hash.sv]
// dynamic lookup table index: direct, crc or xor mapping of the destination address
module table_index_hash (
    input wire logic [1:0] table_index_select,
    input wire logic [47:0] dest_addr,
    output logic [9:0] table_index
);

    function automatic logic [9:0] crc_index(input logic [47:0] a);
        logic [9:0] c;
        logic fb;
        c = '1;
        for (int i = 0; i < 48; i++) begin
            fb = c[9] ^ a[i];
            c = {c[8:0], 1'b0};
            if (fb) begin
                c = c ^ lookup_cfg_pkg::CRC_POLY;
            end
        end
        return c;
    endfunction

    function automatic logic [9:0] xor_index(input logic [47:0] a);
        logic [9:0] x;
        logic [49:0] p;
        x = '0;
        p = {2'h0, a};
        for (int i = 0; i < 5; i++) begin
            x = x ^ p[i*10 +: 10];
        end
        return x;
    endfunction

    always_comb begin
        case (table_index_select)
            lookup_cfg_pkg::INDEX_CRC: table_index = crc_index(dest_addr); // RULE13
            lookup_cfg_pkg::INDEX_XOR: table_index = xor_index(dest_addr); // RULE14
            default: table_index = dest_addr[9:0]; // RULE12
        endcase
    end

endmodule

// [verilog/switch_lookup_global_config.sv]
// global lookup configuration registers with per-frame forwarding decisions
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RULE1: 14-bit payload limit, reset 0x07D0; longer frames are truncated to it.
// RULE2: limits up to 9000 are accepted and applied for jumbo frames.
// RULE3: 16-bit tag type, reset 0x9100, for untagged frames and outer tag.
// RULE4: control bit 7, reset zero, enables vlan forwarding and filtering.
// RULE5: software sets up the vlan table before setting the vlan enable.
// RULE6: bit 6, reset one, drops frames with invalid vlan id.
// RULE7: with bit 6 clear, invalid vlan id frames go to host port only.
// RULE8: unknown vlan forwarding, when enabled, overrides the drop bit.
// RULE9: age count bits 5:3, reset 100b, sets dynamic entry aging time.
// RULE10: every dynamic entry update loads the configured age count.
// RULE11: reserved multicast table consulted only while bit 2 is set.
// RULE12: index select 00 or 11 indexes by low 10 destination bits.
// RULE13: index select 01, the reset value, uses a crc hash.
// RULE14: index select 10 uses an xor hash.
// RULE15: config writes apply from the next frame, never mid-frame.
//
// Our own choice: the AXI4-Lite interface to the registers.
module switch_lookup_global_config (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic frame_start,
    input wire logic [13:0] frame_payload_len,
    input wire logic frame_tagged,
    input wire logic double_tag_en,
    input wire logic vid_invalid,
    input wire logic unknown_vid_fwd_en,
    input wire logic [47:0] dest_addr,
    input wire logic entry_update,
    output logic res_valid,
    output logic res_truncate,
    output logic [13:0] res_payload_len,
    output logic [15:0] res_tag_type,
    output logic res_outer_tag,
    output logic res_vlan_active,
    output logic res_drop,
    output logic res_host_only,
    output logic res_rsvd_mcast_lookup,
    output logic [9:0] res_table_index,
    output logic age_wr_valid,
    output logic [2:0] age_wr_count
);

    typedef struct packed {
        logic [15:0] max_payload_limit;
        logic [15:0] tag_type_identifier;
        logic [7:0] lookup_ctl;
        logic aw_held;
        logic [11:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic res_valid;
        logic res_truncate;
        logic [13:0] res_len;
        logic [15:0] res_tag;
        logic res_outer;
        logic res_vlan;
        logic res_drop;
        logic res_host;
        logic res_rsvd;
        logic [9:0] res_index;
        logic age_valid;
        logic [2:0] age_count;
        logic [7:0] trunc_cnt;
        logic [7:0] drop_cnt;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [9:0] hashed_index;
    logic [13:0] limit;
    logic over_limit;
    logic vlan_on;
    logic filter_invalid;

    //////////////////////////////////////////////////////////////////////////
    // index mapping for the current frame's destination address

    table_index_hash u_hash (
        .table_index_select(s_q.lookup_ctl[lookup_cfg_pkg::CTL_INDEX_MSB:0]),
        .dest_addr(dest_addr),
        .table_index(hashed_index)
    );

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] strb);
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = d[7:0];
        end
        if (strb[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // next state

    assign limit = s_q.max_payload_limit[lookup_cfg_pkg::LIMIT_MSB:0];
    assign over_limit = frame_payload_len > limit; // RULE1 RULE2
    assign vlan_on = s_q.lookup_ctl[lookup_cfg_pkg::CTL_VLAN_EN]; // RULE4
    // the unknown-vid feature owns invalid-vid frames when it is on
    assign filter_invalid = vlan_on && vid_invalid && !unknown_vid_fwd_en; // RULE8

    always_comb begin
        s_d = s_q;
        s_d.res_valid = 1'b0;
        s_d.age_valid = 1'b0;

        // write address and data are taken independently, in either order
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_held = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_held = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.aw_held && s_q.w_held) begin
            s_d.aw_held = 1'b0;
            s_d.w_held = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = lookup_cfg_pkg::RESP_OKAY;
            case ({s_q.aw_addr[11:2], 2'h0})
                lookup_cfg_pkg::ADDR_MAX_PAYLOAD: begin
                    s_d.max_payload_limit = merge16(s_q.max_payload_limit, s_q.w_data,
                                                    s_q.w_strb); // RULE1 RULE2
                end
                lookup_cfg_pkg::ADDR_TAG_TYPE: begin
                    s_d.tag_type_identifier = merge16(s_q.tag_type_identifier, s_q.w_data,
                                                      s_q.w_strb); // RULE3
                end
                lookup_cfg_pkg::ADDR_LOOKUP_CTL: begin
                    if (s_q.w_strb[0]) begin
                        s_d.lookup_ctl = s_q.w_data[7:0];
                    end
                end
                lookup_cfg_pkg::ADDR_STATUS: begin
                end
                default: begin
                    s_d.bresp = lookup_cfg_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        if (s_axi_arvalid && s_axi_arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = lookup_cfg_pkg::RESP_OKAY;
            case ({s_axi_araddr[11:2], 2'h0})
                lookup_cfg_pkg::ADDR_MAX_PAYLOAD: s_d.rdata = {16'h0000, s_q.max_payload_limit};
                lookup_cfg_pkg::ADDR_TAG_TYPE: s_d.rdata = {16'h0000, s_q.tag_type_identifier};
                lookup_cfg_pkg::ADDR_LOOKUP_CTL: s_d.rdata = {24'h000000, s_q.lookup_ctl};
                lookup_cfg_pkg::ADDR_STATUS: s_d.rdata = {16'h0000, s_q.drop_cnt, s_q.trunc_cnt};
                default: begin
                    s_d.rdata = 32'h00000000;
                    s_d.rresp = lookup_cfg_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end

        // decisions use the settings in force when the frame starts and are held
        // until the next frame, so a later write cannot reach a frame in flight
        if (frame_start) begin // RULE15
            s_d.res_valid = 1'b1;
            s_d.res_truncate = over_limit; // RULE1
            s_d.res_len = over_limit ? limit : frame_payload_len; // RULE1 RULE2
            s_d.res_outer = double_tag_en; // RULE3
            s_d.res_tag = (!frame_tagged || double_tag_en) ?
                          s_q.tag_type_identifier : 16'h0000; // RULE3
            s_d.res_vlan = vlan_on; // RULE4
            s_d.res_drop = filter_invalid &&
                           s_q.lookup_ctl[lookup_cfg_pkg::CTL_DROP_INVALID]; // RULE6
            s_d.res_host = filter_invalid &&
                           !s_q.lookup_ctl[lookup_cfg_pkg::CTL_DROP_INVALID]; // RULE7
            s_d.res_rsvd = s_q.lookup_ctl[lookup_cfg_pkg::CTL_RSVD_MCAST]; // RULE11
            s_d.res_index = hashed_index; // RULE12 RULE13 RULE14
            if (over_limit) begin
                s_d.trunc_cnt = s_q.trunc_cnt + 8'h01;
            end
            if (s_d.res_drop) begin
                s_d.drop_cnt = s_q.drop_cnt + 8'h01;
            end
        end

        if (entry_update) begin
            s_d.age_valid = 1'b1;
            s_d.age_count = s_q.lookup_ctl[lookup_cfg_pkg::CTL_AGE_MSB:
                                           lookup_cfg_pkg::CTL_AGE_LSB]; // RULE9 RULE10
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.max_payload_limit <= lookup_cfg_pkg::MAX_PAYLOAD_RST; // RULE1
            s_q.tag_type_identifier <= lookup_cfg_pkg::TAG_TYPE_RST; // RULE3
            s_q.lookup_ctl <= lookup_cfg_pkg::LOOKUP_CTL_RST; // RULE4 RULE6 RULE9 RULE11 RULE13
        end else begin
            s_q <= s_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // outputs

    assign s_axi_awready = !s_q.aw_held && !s_q.bvalid;
    assign s_axi_wready = !s_q.w_held && !s_q.bvalid;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign res_valid = s_q.res_valid;
    assign res_truncate = s_q.res_truncate;
    assign res_payload_len = s_q.res_len;
    assign res_tag_type = s_q.res_tag;
    assign res_outer_tag = s_q.res_outer;
    assign res_vlan_active = s_q.res_vlan;
    assign res_drop = s_q.res_drop;
    assign res_host_only = s_q.res_host;
    assign res_rsvd_mcast_lookup = s_q.res_rsvd;
    assign res_table_index = s_q.res_index;
    assign age_wr_valid = s_q.age_valid;
    assign age_wr_count = s_q.age_count;

    //////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence write_pair_held;
        s_q.aw_held && s_q.w_held;
    endsequence

    sequence write_answered;
        ##1 s_axi_bvalid [*1];
    endsequence

    AST_TRUNC_LIMIT: assert property (frame_start && over_limit |=> // RULE1
        res_truncate && res_payload_len == $past(limit))
        else $error("oversized frame not truncated to limit");

    AST_JUMBO_PASS: assert property (frame_start && limit == 14'h2328 && // RULE2
        frame_payload_len == 14'h2328 |=> !res_truncate && res_payload_len == 14'h2328)
        else $error("jumbo frame at limit truncated");

    AST_TAG_TYPE: assert property (frame_start && !frame_tagged |=> // RULE3
        res_tag_type == $past(s_q.tag_type_identifier))
        else $error("untagged frame missed configured tag type");

    AST_VLAN_OFF: assert property (frame_start && !vlan_on |=> // RULE4
        !res_drop && !res_host_only && !res_vlan_active)
        else $error("vlan filtering acted while disabled");

    AST_DROP_INVALID: assert property (frame_start && filter_invalid && // RULE6
        s_q.lookup_ctl[lookup_cfg_pkg::CTL_DROP_INVALID] |=> res_drop && !res_host_only)
        else $error("invalid vid frame not dropped");

    AST_HOST_INVALID: assert property (frame_start && filter_invalid && // RULE7
        !s_q.lookup_ctl[lookup_cfg_pkg::CTL_DROP_INVALID] |=> res_host_only && !res_drop)
        else $error("invalid vid frame not sent to host");

    AST_UNKNOWN_WINS: assert property (frame_start && unknown_vid_fwd_en |=> // RULE8
        !res_drop && !res_host_only)
        else $error("drop bit applied while unknown vid forwarding on");

    AST_AGE_LOAD: assert property (entry_update |=> age_wr_valid && // RULE10
        age_wr_count == $past(s_q.lookup_ctl[lookup_cfg_pkg::CTL_AGE_MSB:
                                             lookup_cfg_pkg::CTL_AGE_LSB]))
        else $error("age count not loaded on entry update");

    AST_RSVD_MCAST: assert property (frame_start |=> // RULE11
        res_rsvd_mcast_lookup == $past(s_q.lookup_ctl[lookup_cfg_pkg::CTL_RSVD_MCAST]))
        else $error("reserved multicast lookup enable mismatch");

    AST_DIRECT_INDEX: assert property (frame_start && // RULE12
        (s_q.lookup_ctl[lookup_cfg_pkg::CTL_INDEX_MSB:0] == lookup_cfg_pkg::INDEX_DIRECT0 ||
        s_q.lookup_ctl[lookup_cfg_pkg::CTL_INDEX_MSB:0] == lookup_cfg_pkg::INDEX_DIRECT3) |=>
        res_table_index == $past(dest_addr[9:0]))
        else $error("direct index not low destination bits");

    AST_WRITE_RESP: assert property (write_pair_held |-> write_answered) // RULE15
        else $error("write response missing after address and data");

    AST_RESULT_HELD: assert property (!frame_start |=> $stable(res_drop) && // RULE15
        $stable(res_payload_len) && $stable(res_table_index))
        else $error("frame decision changed without a new frame");

endmodule

// [tb/tb.sv]
// self-checking bench for the global lookup configuration register bank
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, aresetn;
    logic [11:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic frame_start, frame_tagged, double_tag_en, vid_invalid, unknown_vid_fwd_en;
    logic [13:0] frame_payload_len, res_payload_len;
    logic [47:0] dest_addr;
    logic entry_update, res_valid, res_truncate, res_outer_tag, res_vlan_active, res_drop;
    logic res_host_only, res_rsvd_mcast_lookup, age_wr_valid;
    logic [15:0] res_tag_type;
    logic [9:0] res_table_index;
    logic [2:0] age_wr_count;
    int mismatches = 0;
    int n_compared = 0;
    logic [31:0] d;
    logic [1:0] r;
    logic [47:0] da;
    switch_lookup_global_config i_switch_lookup_global_config (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .frame_start(frame_start), .frame_payload_len(frame_payload_len),
        .frame_tagged(frame_tagged), .double_tag_en(double_tag_en), .vid_invalid(vid_invalid),
        .unknown_vid_fwd_en(unknown_vid_fwd_en), .dest_addr(dest_addr),
        .entry_update(entry_update), .res_valid(res_valid), .res_truncate(res_truncate),
        .res_payload_len(res_payload_len), .res_tag_type(res_tag_type),
        .res_outer_tag(res_outer_tag), .res_vlan_active(res_vlan_active), .res_drop(res_drop),
        .res_host_only(res_host_only), .res_rsvd_mcast_lookup(res_rsvd_mcast_lookup),
        .res_table_index(res_table_index), .age_wr_valid(age_wr_valid),
        .age_wr_count(age_wr_count)
    );
    //////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    task automatic final_report;
        if (mismatches == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // write: address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
        bit aw_ok, w_ok;
        int n;
        aw_ok = 0;
        w_ok = 0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= v;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (bvalid === 1'b1) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1;
                wvalid <= 1'b0;
            end
        end
        if (n == 100) chk(32'h0, 32'h1, "write hang");
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (rvalid === 1'b1) begin
                v = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        if (n == 100) chk(32'h0, 32'h1, "read hang");
    endtask
    // flags: tagged, double tag, invalid vid, unknown vid forwarding
    task automatic frm(input logic [13:0] len, input logic [3:0] f);
        @(posedge aclk);
        frame_start <= 1'b1;
        frame_payload_len <= len;
        {frame_tagged, double_tag_en, vid_invalid, unknown_vid_fwd_en} <= f;
        @(posedge aclk);
        frame_start <= 1'b0;
        #1;
        chk(32'(res_valid), 32'h1, "res_valid");
    endtask
    task automatic age(input logic [2:0] exp);
        @(posedge aclk);
        entry_update <= 1'b1;
        @(posedge aclk);
        entry_update <= 1'b0;
        #1;
        chk({28'h0, age_wr_valid, age_wr_count}, {29'h1, exp}, "age write");
    endtask
    function automatic logic [9:0] crc_exp(input logic [47:0] a);
        logic [9:0] c;
        logic fb;
        c = '1;
        for (int i = 0; i < 48; i++) begin
            fb = c[9] ^ a[i];
            c = {c[8:0], 1'b0};
            if (fb) c = c ^ lookup_cfg_pkg::CRC_POLY;
        end
        return c;
    endfunction
    function automatic logic [9:0] xor_exp(input logic [47:0] a);
        logic [49:0] x;
        x = {2'h0, a};
        return x[9:0] ^ x[19:10] ^ x[29:20] ^ x[39:30] ^ x[49:40];
    endfunction
    //////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        final_report;
    end
    initial begin
        {awaddr, araddr, wdata, frame_payload_len, dest_addr} = '0;
        {awvalid, wvalid, bready, arvalid, rready, frame_start, entry_update} = '0;
        {frame_tagged, double_tag_en, vid_invalid, unknown_vid_fwd_en} = '0;
        wstrb = 4'hF;
        aresetn = 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(lookup_cfg_pkg::ADDR_MAX_PAYLOAD, d, r);
        chk(d, 32'h0000_07D0, "limit reset");
        rd(lookup_cfg_pkg::ADDR_TAG_TYPE, d, r);
        chk(d, 32'h0000_9100, "tag reset");
        rd(lookup_cfg_pkg::ADDR_LOOKUP_CTL, d, r);
        chk(d, 32'h0000_0061, "ctl reset");
        rd(12'h004, d, r);
        chk(d, 32'h0000_0000, "unmapped read data");
        chk(32'(r), 32'h2, "unmapped read resp");
        wr(12'h004, 32'h0000_FFFF, r);
        chk(32'(r), 32'h2, "unmapped write");
        // equal length passes, one more is cut to the limit
        frm(14'h07D0, 4'h0);
        chk(32'({res_truncate, res_payload_len}), 32'h0000_07D0, "at limit");
        chk({res_tag_type, 15'h0, res_outer_tag}, 32'h9100_0000, "untagged");
        frm(14'h07D1, 4'h0);
        chk(32'({res_truncate, res_payload_len}), 32'h0000_47D0, "over limit");
        wr(lookup_cfg_pkg::ADDR_MAX_PAYLOAD, 32'h0000_2328, r);
        chk(32'(r), 32'h0, "write okay");
        frm(14'h2328, 4'h0);
        chk(32'({res_truncate, res_payload_len}), 32'h0000_2328, "jumbo");
        frm(14'h2329, 4'h0);
        chk(32'({res_truncate, res_payload_len}), 32'h0000_6328, "jumbo over");
        frm(14'h0040, 4'h8);
        chk({res_tag_type, 15'h0, res_outer_tag}, 32'h0000_0000, "tagged");
        wr(lookup_cfg_pkg::ADDR_TAG_TYPE, 32'h0000_88A8, r);
        frm(14'h0040, 4'hC);
        chk({res_tag_type, 15'h0, res_outer_tag}, 32'h88A8_0001, "outer tag");
        // vlan disabled at reset: invalid id has no effect
        frm(14'h0040, 4'h2);
        chk(32'({res_vlan_active, res_drop, res_host_only}), 32'h0, "vlan off");
        age(3'h4);
        // no membership table sits in this bench, so the enable needs no setup first
        wr(lookup_cfg_pkg::ADDR_LOOKUP_CTL, 32'h0000_00C1, r);
        frm(14'h0040, 4'h2);
        chk(32'({res_vlan_active, res_drop, res_host_only}), 32'h6, "drop invalid");
        age(3'h0);
        wr(lookup_cfg_pkg::ADDR_LOOKUP_CTL, 32'h0000_00B9, r);
        rd(lookup_cfg_pkg::ADDR_LOOKUP_CTL, d, r);
        chk(d, 32'h0000_00B9, "ctl readback");
        frm(14'h0040, 4'h2);
        chk(32'({res_vlan_active, res_drop, res_host_only}), 32'h5, "host only");
        age(3'h7);
        frm(14'h0040, 4'h3);
        chk(32'({res_drop, res_host_only}), 32'h0, "unknown vid wins");
        frm(14'h0040, 4'h0);
        chk(32'(res_rsvd_mcast_lookup), 32'h0, "rsvd off");
        wr(lookup_cfg_pkg::ADDR_LOOKUP_CTL, 32'h0000_0005, r);
        frm(14'h0040, 4'h0);
        chk(32'({res_rsvd_mcast_lookup, res_vlan_active}), 32'h2, "rsvd on");
        da = 48'hA5C3_1F0E_9B77;
        @(posedge aclk);
        dest_addr <= da;
        for (int s = 0; s < 4; s++) begin
            wr(lookup_cfg_pkg::ADDR_LOOKUP_CTL, 32'(s), r);
            frm(14'h0040, 4'h0);
            case (s)
                1: chk(32'(res_table_index), 32'(crc_exp(da)), "crc index");
                2: chk(32'(res_table_index), 32'(xor_exp(da)), "xor index");
                default: chk(32'(res_table_index), 32'(da[9:0]), "direct index");
            endcase
        end
        // two truncated frames and one dropped frame so far
        rd(lookup_cfg_pkg::ADDR_STATUS, d, r);
        chk(d, 32'h0000_0102, "status counts");
        chk(32'(r), 32'h0, "read okay");
        wr(lookup_cfg_pkg::ADDR_STATUS, 32'h0000_FFFF, r);
        chk(32'(r), 32'h0, "status write okay");
        rd(lookup_cfg_pkg::ADDR_STATUS, d, r);
        chk(d, 32'h0000_0102, "status unchanged");
        // only the low byte lane is enabled: the upper tag byte must survive
        @(posedge aclk);
        wstrb <= 4'h1;
        wr(lookup_cfg_pkg::ADDR_TAG_TYPE, 32'h0000_1234, r);
        rd(lookup_cfg_pkg::ADDR_TAG_TYPE, d, r);
        chk(d, 32'h0000_8834, "byte lane write");
        final_report;
    end
endmodule
